// ==== bench/aux_hub_asserts.sv ====
// checks on the side sensor hub ports
// assumes one clock, async active-low reset; bound to the hub below
`timescale 1ns/1ps
module aux_hub_asserts #(
	parameter NL_PULSE_CYC = 20
) (
	input wire        i_clk_sys,
	input wire        i_resetn,
	input wire        i_rd_addr_write,
	input wire        i_wr_addr_write,
	input wire [1:0]  i_rd_burst,
	input wire        i_data_read,
	input wire        i_status1_read,
	input wire        i_latch_mode,
	input wire        i_map_pin_one,
	input wire        i_pin_one_out_en,
	input wire        i_pin_one_drain_style_select,
	input wire        i_pin_one_active_high,
	input wire        i_pin_one_input_en,
	input wire        i_map_pin_two,
	input wire        i_pin_two_out_en,
	input wire        i_pin_two_drain_style_select,
	input wire        o_link_busy,
	input wire [1:0]  o_link_mode,
	input wire [63:0] o_data_bytes,
	input wire        o_drdy_aux,
	input wire        o_int_aux_drdy,
	input wire        o_irq_pin_one,
	input wire        o_irq_pin_two_oe,
	input wire        o_queue_mark_pin_one,
	input wire        o_scl_oe
);
	integer hi_cnt;
	wire    pin_act = o_irq_pin_one ~^ i_pin_one_active_high;
	// pin one active length, bounds the non-latched pulse
	always @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn)
			hi_cnt <= 0;
		else
			hi_cnt <= pin_act ? hi_cnt + 1 : 0;
	end
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);
	a_busy_on_trigger: assert property (o_link_mode == 2'h1 && !o_link_busy && (i_wr_addr_write || i_rd_addr_write) |=> o_link_busy) else $error("no busy");
	a_none_stays_quiet: assert property (o_link_mode == 2'h0 && !o_link_busy |=> !o_link_busy && !o_scl_oe) else $error("link active");
	a_scl_low_span: assert property ($rose(o_scl_oe) |-> ##249 o_scl_oe ##1 !o_scl_oe) else $error("scl low length");
	a_drdy_source: assert property ($rose(o_drdy_aux) |-> o_link_mode == 2'h2 && (i_rd_burst != 2'h3 || o_data_bytes[48])) else $error("bad data ready");
	a_status_clear: assert property (i_status1_read && !o_link_busy && !$past(o_link_busy) |=> !o_int_aux_drdy) else $error("status not cleared");
	a_data_clear: assert property (i_data_read && !o_link_busy && !$past(o_link_busy) |=> !o_drdy_aux) else $error("ready not cleared");
	a_latched_pin: assert property (i_latch_mode && i_map_pin_one && i_pin_one_out_en && !i_pin_one_drain_style_select |-> o_irq_pin_one == (o_int_aux_drdy ~^ i_pin_one_active_high)) else $error("latched pin wrong");
	a_unmapped_quiet: assert property (!i_map_pin_two && i_pin_two_out_en && i_pin_two_drain_style_select |-> !o_irq_pin_two_oe) else $error("unmapped pin driven");
	a_input_follow: assert property (i_pin_one_out_en && i_pin_one_input_en |-> o_queue_mark_pin_one == o_irq_pin_one) else $error("input not own output");
	a_pulse_bound: assert property (!i_latch_mode && i_pin_one_out_en |-> hi_cnt <= NL_PULSE_CYC) else $error("pulse too long");
	c_setup_done: cover property ($fell(o_link_busy) && o_link_mode == 2'h1);
	c_sample_ready: cover property ($rose(o_drdy_aux));
	c_latched_read: cover property (i_latch_mode && o_int_aux_drdy && i_status1_read);
endmodule // aux_hub_asserts
bind aux_sensor_i2c_hub aux_hub_asserts #(.NL_PULSE_CYC(NL_PULSE_CYC)) aux_hub_asserts_i (
	.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_rd_addr_write(i_rd_addr_write),
	.i_wr_addr_write(i_wr_addr_write), .i_rd_burst(i_rd_burst), .i_data_read(i_data_read),
	.i_status1_read(i_status1_read), .i_latch_mode(i_latch_mode), .i_map_pin_one(i_map_pin_one),
	.i_pin_one_out_en(i_pin_one_out_en), .i_pin_one_drain_style_select(i_pin_one_drain_style_select),
	.i_pin_one_active_high(i_pin_one_active_high), .i_pin_one_input_en(i_pin_one_input_en),
	.i_map_pin_two(i_map_pin_two), .i_pin_two_out_en(i_pin_two_out_en),
	.i_pin_two_drain_style_select(i_pin_two_drain_style_select), .o_link_busy(o_link_busy),
	.o_link_mode(o_link_mode), .o_data_bytes(o_data_bytes), .o_drdy_aux(o_drdy_aux),
	.o_int_aux_drdy(o_int_aux_drdy), .o_irq_pin_one(o_irq_pin_one),
	.o_irq_pin_two_oe(o_irq_pin_two_oe), .o_queue_mark_pin_one(o_queue_mark_pin_one),
	.o_scl_oe(o_scl_oe)
);

// ==== bench/aux_sensor_model.sv ====
// i2c side sensor model: 256 byte map, auto-incrementing pointer
// assumes the bench resolves scl and sda with pull-ups; only sda is pulled
`timescale 1ns/1ps
module aux_sensor_model #(
	parameter [6:0] ADDR = 7'h13
) (
	// bus lines as seen on the wire
	input  wire i_scl,
	input  wire i_sda,
	// pull sda low while high
	output reg  o_sda_oe
);
	reg [7:0] mem [0:255];
	reg [7:0] ptr;
	reg [7:0] sh;
	reg [2:0] ph;
	reg       act;
	reg       nack;
	integer   bc;
	integer   rcnt;
	integer   wcnt;
	integer   i;
	// known contents so the bench can predict every byte
	initial begin
		for (i = 0; i < 256; i = i + 1)
			mem[i] = i[7:0] ^ 8'hC3;
		o_sda_oe = 1'b0;
		act = 1'b0;
		nack = 1'b0;
		ph = 3'h4;
		bc = 0;
		rcnt = 0;
		wcnt = 0;
		ptr = 8'h00;
		sh = 8'h00;
	end
	// start or repeated start; scl is never held, so no stretching
	always @(negedge i_sda) if (i_scl === 1'b1) begin
		act = 1'b1;
		bc = -1; // the scl fall ending the start is no bit
		ph = 3'h0;
		o_sda_oe = 1'b0;
	end
	// stop ends the frame and frees sda
	always @(posedge i_sda) if (i_scl === 1'b1) begin
		act = 1'b0;
		o_sda_oe = 1'b0;
	end
	// sample bits and the master's ack
	always @(posedge i_scl) if (act) begin
		if (bc < 8 && ph != 3'h3)
			sh = {sh[6:0], i_sda};
		if (bc == 8 && ph == 3'h3)
			nack = i_sda;
	end
	// drive on falling scl only, never while scl is high
	always @(negedge i_scl) if (act) begin
		if (bc == 7) begin
			bc = 8;
			o_sda_oe = (ph != 3'h3 && ph != 3'h4);
			case (ph)
			3'h0: if (sh[7:1] == ADDR) begin
				ph = sh[0] ? 3'h3 : 3'h1;
				nack = 1'b0;
			end else begin
				ph = 3'h4;
				o_sda_oe = 1'b0;
			end
			3'h1: begin
				ptr = sh;
				ph = 3'h2;
			end
			3'h2: begin
				mem[ptr] = sh;
				ptr = ptr + 8'h01;
				wcnt = wcnt + 1;
			end
			default: ;
			endcase
		end else if (bc == 8) begin
			bc = 0;
			o_sda_oe = 1'b0;
			if (ph == 3'h3 && !nack) begin
				sh = mem[ptr];
				ptr = ptr + 8'h01;
				rcnt = rcnt + 1;
				o_sda_oe = ~sh[7];
			end
		end else begin
			if (ph == 3'h3)
				o_sda_oe = ~sh[6 - bc];
			bc = bc + 1;
		end
	end
endmodule // aux_sensor_model

// ==== bench/testbench.sv ====
// bench: setup transfers, data loop, irq pins, sample queue
// assumes the sensor model on the wire, checker bound to hub
`timescale 1ns/1ps
`include "aux_hub_map.vh"
module testbench;
	localparam NLP = 20;
	localparam SMP = 70000;
	reg         clk, rstn, man, dps, pwr, en, rstb, wstb, dread, sread, latch, fready, x1, x2;
	reg  [6:0]  dev;
	reg  [1:0]  burst;
	reg  [3:0]  off;
	reg  [4:0]  p1c, p2c;
	reg  [7:0]  ra, wa, wd;
	reg  [63:0] exp;
	wire        busy, nack, drdy, intf, p1, p1oe, p2, p2oe, m1, m2, scl_oe, sda_oe, sen_oe, fval;
	wire [1:0]  mode;
	wire [63:0] data;
	wire [7:0]  fdata, scl_v, sda_v;
	wire        scl = ~scl_oe;
	wire        sda = ~(sda_oe | sen_oe);
	integer     err_count, compares, k, n, r0, w0;
	aux_sensor_i2c_hub #(.OFFSET_STEP_CYC(200), .NL_PULSE_CYC(NLP), .SAMPLE_CYC(SMP)) aux_sensor_i2c_hub_i (
		.i_clk_sys(clk), .i_resetn(rstn), .i_side_link_manual_select(man), .i_deep_power_saving(dps),
		.i_side_link_power_on(pwr), .i_side_link_enable(en), .i_dev_addr(dev), .i_rd_burst(burst),
		.i_offset_code(off), .i_rd_addr(ra), .i_rd_addr_write(rstb), .i_wr_addr(wa),
		.i_wr_addr_write(wstb), .i_wr_data(wd), .o_link_busy(busy), .o_nack_seen(nack),
		.o_link_mode(mode), .o_data_bytes(data), .o_drdy_aux(drdy), .o_int_aux_drdy(intf),
		.i_data_read(dread), .i_status1_read(sread), .i_latch_mode(latch), .i_map_pin_one(p1c[4]),
		.i_map_pin_two(p2c[4]), .i_pin_one_out_en(p1c[3]), .i_pin_one_drain_style_select(p1c[2]),
		.i_pin_one_active_high(p1c[1]), .i_pin_one_input_en(p1c[0]), .i_pin_two_out_en(p2c[3]),
		.i_pin_two_drain_style_select(p2c[2]), .i_pin_two_active_high(p2c[1]),
		.i_pin_two_input_en(p2c[0]), .i_irq_pin_one(x1), .o_irq_pin_one(p1), .o_irq_pin_one_oe(p1oe),
		.i_irq_pin_two(x2), .o_irq_pin_two(p2), .o_irq_pin_two_oe(p2oe), .o_queue_mark_pin_one(m1),
		.o_queue_mark_pin_two(m2), .o_scl(), .o_scl_oe(scl_oe), .i_sda(sda), .o_sda(),
		.o_sda_oe(sda_oe), .o_fifo_valid(fval), .i_fifo_ready(fready), .o_fifo_data(fdata));
	aux_sensor_model #(.ADDR(7'h13)) aux_sensor_model_i (.i_scl(scl), .i_sda(sda), .o_sda_oe(sen_oe));
	// model contents, worked out independently
	function [7:0] f(input [7:0] a);
		f = a ^ 8'hC3;
	endfunction
	task check(input [63:0] got, input [63:0] want);
		begin
			compares = compares + 1;
			if (got !== want) begin
				err_count = err_count + 1;
				$display("[FAIL] %0t got %h want %h", $time, got, want);
			end
		end
	endtask
	task conclude;
		begin
			$display("errors %0d compares %0d", err_count, compares);
			if (err_count == 0 && compares > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	// one-cycle strobe, wait out the transfer; a refused one never goes busy
	task trig(input wr, input [7:0] a);
		integer t;
		begin
			@(posedge clk);
			if (wr) begin wa <= a; wstb <= 1'b1; end else begin ra <= a; rstb <= 1'b1; end
			@(posedge clk);
			wstb <= 1'b0;
			rstb <= 1'b0;
			t = 0;
			while (busy !== 1'b1 && t < 4) begin @(posedge clk); t = t + 1; end
			while (busy === 1'b1 && t < 90000) begin @(posedge clk); t = t + 1; end
			if (t >= 90000) begin err_count = err_count + 1; $display("[FAIL] %0t link stuck", $time); end
		end
	endtask
	// a sample may take two loop periods after enable
	task wait_drdy;
		integer t;
		begin
			t = 0;
			while (drdy !== 1'b1 && t < 3 * SMP) begin @(posedge clk); t = t + 1; end
			if (t >= 3 * SMP) begin err_count = err_count + 1; $display("[FAIL] %0t no sample", $time); end
		end
	endtask
	task clear_flags(input d, input s);
		begin
			@(posedge clk);
			dread <= d;
			sread <= s;
			@(posedge clk);
			dread <= 1'b0;
			sread <= 1'b0;
			repeat (3) @(posedge clk);
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// hang guard, past the two sample periods
	initial begin
		#2500000;
		err_count = err_count + 1;
		conclude;
	end
	initial begin
		err_count = 0; compares = 0; rstn = 0; man = 1; dps = 1; pwr = 0; en = 0; rstb = 0; wstb = 0;
		dread = 0; sread = 0; latch = 0; fready = 0; x1 = 0; x2 = 0; dev = 7'h13; burst = `BURST_8;
		off = 4'h0; ra = 8'h10; wa = 8'h4B; wd = 8'hA5; p1c = 5'h1B; p2c = 5'h0C; exp = 64'h0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		check(busy, 1'b0);
		check(scl_oe, 1'b0);
		check(mode, 2'h0);
		r0 = aux_sensor_model_i.rcnt;
		trig(0, 8'h10);
		check(aux_sensor_model_i.rcnt - r0, 0);
		dps <= 1'b0;
		en <= 1'b1;
		repeat (2) @(posedge clk);
		check(mode, 2'h1);
		w0 = aux_sensor_model_i.wcnt;
		trig(1, 8'h4B);
		check(aux_sensor_model_i.mem[8'h4B], 8'hA5);
		check(aux_sensor_model_i.wcnt - w0, 1);
		check(nack, 1'b0);
		burst <= `BURST_2;
		r0 = aux_sensor_model_i.rcnt;
		trig(0, 8'h10);
		check(data[15:0], {f(8'h11), f(8'h10)});
		check(aux_sensor_model_i.rcnt - r0, 2);
		dev <= 7'h22;
		wd <= 8'h3C;
		trig(1, 8'h4B);
		check(nack, 1'b1);
		check(aux_sensor_model_i.mem[8'h4B], 8'hA5);
		en <= 1'b0;
		dev <= 7'h13;
		ra <= 8'h42;
		wa <= 8'h4C;
		wd <= 8'h02;
		burst <= `BURST_8;
		@(posedge clk);
		man <= 1'b0;
		pwr <= 1'b1;
		en <= 1'b1;
		repeat (2) @(posedge clk);
		check(mode, 2'h2);
		for (k = 0; k < 8; k = k + 1)
			exp[8 * k +: 8] = f(8'h42 + k[7:0]);
		wait_drdy;
		repeat (2) @(posedge clk);
		check({p1, p1oe, m1, p2oe, p2}, 5'h1C);
		check(data, exp);
		check(aux_sensor_model_i.mem[8'h4C], 8'h02);
		repeat (NLP + 5) @(posedge clk);
		check(p1, 1'b0);
		check(intf, 1'b1);
		check(p2oe, 1'b0);
		clear_flags(1'b1, 1'b1);
		check(drdy, 1'b0);
		check(intf, 1'b0);
		latch <= 1'b1;
		wait_drdy;
		repeat (NLP + 10) @(posedge clk);
		check(p1, 1'b1);
		clear_flags(1'b0, 1'b1);
		check(p1, 1'b0);
		check(drdy, 1'b1);
		// two samples queued while stalled, taken in order
		fready <= 1'b1;
		k = 0;
		n = 0;
		while (k < 16 && n < 200) begin
			@(posedge clk);
			n = n + 1;
			if (fval === 1'b1) begin
				check(fdata, f(8'h42 + {5'h00, k[2:0]}));
				k = k + 1;
			end
		end
		check(k, 16);
		@(posedge clk);
		check(fval, 1'b0);
		p2c <= 5'h01;
		x2 <= 1'b1;
		repeat (4) @(posedge clk);
		check(m2, 1'b1);
		conclude;
	end
endmodule // testbench

// ==== common/aux_hub_map.vh ====
// side sensor hub constants: link and irq timing, burst codes
// assumes the SYS_CLK_HZ clock; times in ns
`ifndef AUX_HUB_MAP_VH
`define AUX_HUB_MAP_VH

`define SYS_CLK_HZ       200000000
`define SYS_CLK_NS       5
`define LINK_BIT_HZ      400000
`define QUARTER_CYC      (`SYS_CLK_HZ / (`LINK_BIT_HZ * 4))
`define OFFSET_STEP_NS   2500000
`define NL_PULSE_NS      156250
`define SAMPLE_PERIOD_NS 40000000
`define OFFSET_STEP_CYC  (`OFFSET_STEP_NS / `SYS_CLK_NS)
`define NL_PULSE_CYC     (`NL_PULSE_NS / `SYS_CLK_NS)
`define SAMPLE_CYC       (`SAMPLE_PERIOD_NS / `SYS_CLK_NS)
`define BURST_1          2'h0
`define BURST_2          2'h1
`define BURST_6          2'h2
`define BURST_8          2'h3
`define SAMPLE_RDY_BIT   48
`define FIFO_WIDTH       8
`define FIFO_DEPTH       32
`define IF_ENABLE_RESET  1'h0

`endif

// ==== verilog/aux_byte_fifo.v ====
// FIFO queueing bytes fetched from the side sensor
// assumes one clock, async active-low reset; depth a power of two
`timescale 1ns/1ps
module aux_byte_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	// clock and reset
	input  wire             i_clk_sys,
	input  wire             i_resetn,
	// fill side
	input  wire             i_in_valid,
	output wire             o_in_ready,
	input  wire [WIDTH-1:0] i_in_data,
	// drain side
	output reg              o_out_valid,
	input  wire             i_out_ready,
	output reg  [WIDTH-1:0] o_out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;
	wire            push;
	wire            pop;

	assign o_in_ready = (count != DEPTH[AW:0]);
	assign push       = i_in_valid & o_in_ready;
	// refill the output register when empty or taken
	assign pop        = (count != {(AW+1){1'b0}}) & (~o_out_valid | i_out_ready);

	// storage needs no reset
	always @(posedge i_clk_sys) begin
		if (push)
			mem[wr_ptr] <= i_in_data;
	end

	// pointers, count, read data
	always @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_ptr      <= {AW{1'b0}};
			rd_ptr      <= {AW{1'b0}};
			count       <= {(AW+1){1'b0}};
			o_out_valid <= 1'b0;
			o_out_data  <= {WIDTH{1'b0}};
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop) begin
				rd_ptr      <= rd_ptr + 1'b1;
				o_out_data  <= mem[rd_ptr];
				o_out_valid <= 1'b1;
			end else if (i_out_ready) begin
				o_out_valid <= 1'b0;
			end
			count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule // aux_byte_fifo

// ==== verilog/aux_sensor_i2c_hub.v ====
// i2c master hub for one side sensor, with drdy irq pins
// assumes config ports come from host logic on i_clk_sys;
// i_sda and irq pin inputs are synchronised here
// Function
// [RL1] link runs at fixed 400 kHz
// [RL2] three modes: no access, setup, data
// [RL3] setup: read-address write starts burst read
// [RL4] manual write sends exactly one byte
// [RL5] host loads write data before write address
// [RL6] busy set at trigger, cleared at end
// [RL7] data mode loops reads; data6 bit0 ready
// [RL8] data-ready fires; non-latched clears after 1/6400s
// [RL9] status read and data read clear flags
// [RL10] data mode triggers forced measurement by write
// [RL11] burst length from burst field, 0b11=8
// [RL12] trigger 2.5..37.5 ms before update; zero follows
// [RL13] enable resets off; disable only stops link
// [RL14] programmed 7-bit address used every transfer
// [RL15] host disables link while changing addresses
// [RL16] no clock stretching; single master link
// [RL17] samples stored in registers and FIFO
// [RL18] latched: read clears, live condition reasserts; here only a new sample reasserts
// [RL19] non-latched: pin follows condition, status sticky
// [RL20] source drives pin only when mapped
// [RL21] pin enable, drain style, level, input follow
// [RL22] read: pointer write, restart, read, NACK, stop
`timescale 1ns/1ps
`include "aux_hub_map.vh"
module aux_sensor_i2c_hub #(
	parameter OFFSET_STEP_CYC = `OFFSET_STEP_CYC,
	parameter NL_PULSE_CYC    = `NL_PULSE_CYC,
	parameter SAMPLE_CYC      = `SAMPLE_CYC
) (
	// clock and reset
	input  wire        i_clk_sys,
	input  wire        i_resetn,
	// mode controls
	input  wire        i_side_link_manual_select,
	input  wire        i_deep_power_saving,
	input  wire        i_side_link_power_on,
	input  wire        i_side_link_enable,
	// link configuration
	input  wire [6:0]  i_dev_addr,
	input  wire [1:0]  i_rd_burst,
	input  wire [3:0]  i_offset_code,
	input  wire [7:0]  i_rd_addr,
	input  wire        i_rd_addr_write,
	input  wire [7:0]  i_wr_addr,
	input  wire        i_wr_addr_write,
	input  wire [7:0]  i_wr_data,
	// status
	output reg         o_link_busy,
	output reg         o_nack_seen,
	output wire [1:0]  o_link_mode,
	output reg  [63:0] o_data_bytes,
	output reg         o_drdy_aux,
	output reg         o_int_aux_drdy,
	input  wire        i_data_read,
	input  wire        i_status1_read,
	// interrupt configuration
	input  wire        i_latch_mode,
	input  wire        i_map_pin_one,
	input  wire        i_map_pin_two,
	input  wire        i_pin_one_out_en,
	input  wire        i_pin_one_drain_style_select,
	input  wire        i_pin_one_active_high,
	input  wire        i_pin_one_input_en,
	input  wire        i_pin_two_out_en,
	input  wire        i_pin_two_drain_style_select,
	input  wire        i_pin_two_active_high,
	input  wire        i_pin_two_input_en,
	// interrupt pins
	input  wire        i_irq_pin_one,
	output wire        o_irq_pin_one,
	output wire        o_irq_pin_one_oe,
	input  wire        i_irq_pin_two,
	output wire        o_irq_pin_two,
	output wire        o_irq_pin_two_oe,
	output wire        o_queue_mark_pin_one,
	output wire        o_queue_mark_pin_two,
	// side sensor i2c pins, open drain
	output wire        o_scl,
	output wire        o_scl_oe,
	input  wire        i_sda,
	output wire        o_sda,
	output wire        o_sda_oe,
	// sample queue drain side
	output wire        o_fifo_valid,
	input  wire        i_fifo_ready,
	output wire [7:0]  o_fifo_data
);
	localparam S_IDLE  = 3'h0;
	localparam S_START = 3'h1;
	localparam S_TX    = 3'h2;
	localparam S_TXACK = 3'h3;
	localparam S_RX    = 3'h4;
	localparam S_RXACK = 3'h5;
	localparam S_STOP  = 3'h6;
	localparam ST_AW   = 2'h0;
	localparam ST_PTR  = 2'h1;
	localparam ST_WD   = 2'h2;
	localparam ST_AR   = 2'h3;
	localparam M_NONE  = 2'h0;
	localparam M_SETUP = 2'h1;
	localparam M_DATA  = 2'h2;

	// burst field to byte count
	function [3:0] burst_len;
		input [1:0] code;
		begin
			case (code)
				`BURST_1: burst_len = 4'h1;
				`BURST_2: burst_len = 4'h2;
				`BURST_6: burst_len = 4'h6;
				default:  burst_len = 4'h8;
			endcase
		end
	endfunction

	// pin drive from irq level: {output enable, pin value}
	function [1:0] pin_drive;
		input active;
		input out_en;
		input drain;
		input high;
		reg value;
		begin
			value = active ~^ high;
			if (drain)
				pin_drive = {out_en & ~value, 1'b0};
			else
				pin_drive = {out_en, value};
		end
	endfunction

	reg  [2:0]  state;
	reg  [1:0]  q;
	reg  [2:0]  bitcnt;
	reg  [1:0]  stage;
	reg  [7:0]  shreg;
	reg  [7:0]  ptr;
	reg  [7:0]  wbyte;
	reg  [2:0]  rx_idx;
	reg  [3:0]  rd_len;
	reg         is_read;
	reg         loop_xfer;
	reg         sda_low;
	reg         scl_low;
	reg         pend_wr;
	reg         pend_rd;
	reg         done_loop;
	reg  [8:0]  qcnt;
	reg  [31:0] per_cnt;
	reg  [31:0] pulse_cnt;
	reg  [1:0]  sda_sync;
	reg  [1:0]  pin1_sync;
	reg  [1:0]  pin2_sync;
	wire        sda_s;
	wire        qtick;
	wire        adv;
	wire        stall;
	wire        setup_mode;
	wire        data_mode;
	wire        manual_rd;
	wire        manual_wr;
	wire        last_rx;
	wire        fifo_push;
	wire        fifo_in_ready;
	wire        new_sample;
	wire        irq_level;
	wire [31:0] trig_point;
	wire [1:0]  drv1;
	wire [1:0]  drv2;

	// mode decode; setup also needs the link enabled
	assign setup_mode  = i_side_link_manual_select & ~i_deep_power_saving
	                     & i_side_link_enable; // [RL2]
	assign data_mode   = ~i_side_link_manual_select & i_side_link_power_on
	                     & i_side_link_enable; // [RL2] [RL13]
	assign o_link_mode = data_mode ? M_DATA : (setup_mode ? M_SETUP : M_NONE);
	assign manual_rd   = setup_mode & i_rd_addr_write; // [RL3]
	assign manual_wr   = setup_mode & i_wr_addr_write; // [RL4] [RL5]

	// pin inputs pass two flops
	always @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			sda_sync  <= 2'h3;
			pin1_sync <= 2'h0;
			pin2_sync <= 2'h0;
		end else begin
			sda_sync  <= {sda_sync[0], i_sda};
			pin1_sync <= {pin1_sync[0], i_irq_pin_one};
			pin2_sync <= {pin2_sync[0], i_irq_pin_two};
		end
	end
	assign sda_s = sda_sync[1];

	// quarter-bit enable, four per scl period
	always @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn)
			qcnt <= 9'h000;
		else if (qcnt == `QUARTER_CYC - 1) // [RL1]
			qcnt <= 9'h000;
		else
			qcnt <= qcnt + 9'h001;
	end
	assign qtick = (qcnt == `QUARTER_CYC - 1);

	// a full queue holds scl high rather than lose a byte
	assign stall = (state == S_RX) & (q == 2'h3) & (bitcnt == 3'h7) & loop_xfer
	               & ~fifo_in_ready;
	assign adv       = qtick & ~stall;
	assign fifo_push = adv & (state == S_RX) & (q == 2'h3) & (bitcnt == 3'h7)
	                   & loop_xfer; // [RL17]
	assign last_rx   = ({1'b0, rx_idx} == rd_len - 4'h1);

	// loop timer; zero offset triggers right after the update
	assign trig_point = (i_offset_code == 4'h0) ? SAMPLE_CYC - 1
	                    : i_offset_code * OFFSET_STEP_CYC; // [RL12]
	always @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn)
			per_cnt <= 32'h0;
		else if (!data_mode || per_cnt == 32'h0)
			per_cnt <= SAMPLE_CYC - 1;
		else
			per_cnt <= per_cnt - 32'h1;
	end

	// transfer sequencer; scl/sda only pull low
	always @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			state <= S_IDLE;
			q <= 2'h0;
			bitcnt <= 3'h0;
			stage <= ST_AW;
			shreg <= 8'h00;
			ptr <= 8'h00;
			wbyte <= 8'h00;
			rx_idx <= 3'h0;
			rd_len <= 4'h1;
			is_read <= 1'b0;
			loop_xfer <= 1'b0;
			sda_low <= 1'b0;
			scl_low <= 1'b0;
			pend_wr <= 1'b0;
			pend_rd <= 1'b0;
			done_loop <= 1'b0;
			o_link_busy <= 1'b0;
			o_nack_seen <= 1'b0;
			o_data_bytes <= 64'h0;
		end else begin
			done_loop <= 1'b0;
			case (state)
				S_IDLE: begin
					q <= 2'h0;
					// transfers start only in idle
					if (manual_rd || manual_wr || (data_mode && (pend_wr || pend_rd))) begin
						state       <= S_START;
						stage       <= ST_AW;
						o_link_busy <= 1'b1; // [RL6]
						o_nack_seen <= 1'b0;
						rd_len      <= burst_len(i_rd_burst); // [RL11]
						wbyte       <= i_wr_data; // [RL5]
						if (manual_rd) begin
							is_read   <= 1'b1; // [RL3]
							ptr       <= i_rd_addr;
							loop_xfer <= 1'b0;
						end else if (manual_wr) begin
							is_read   <= 1'b0; // [RL4]
							ptr       <= i_wr_addr;
							loop_xfer <= 1'b0;
						end else if (pend_wr) begin
							is_read   <= 1'b0; // [RL10]
							ptr       <= i_wr_addr;
							loop_xfer <= 1'b1;
							pend_wr   <= 1'b0;
						end else begin
							is_read   <= 1'b1; // [RL7]
							ptr       <= i_rd_addr;
							loop_xfer <= 1'b1;
							pend_rd   <= 1'b0;
						end
					end
				end
				S_START: if (adv) begin
					q <= q + 2'h1;
					case (q)
						2'h0: sda_low <= 1'b0;
						2'h1: scl_low <= 1'b0;
						2'h2: sda_low <= 1'b1;
						default: begin
							scl_low <= 1'b1;
							bitcnt  <= 3'h0;
							shreg   <= {i_dev_addr, stage == ST_AR}; // [RL14]
							state   <= S_TX;
						end
					endcase
				end
				S_TX: if (adv) begin
					q <= q + 2'h1;
					case (q)
						2'h0: sda_low <= ~shreg[7];
						2'h1: scl_low <= 1'b0; // [RL16]
						2'h2: scl_low <= 1'b0;
						default: begin
							scl_low <= 1'b1;
							shreg   <= {shreg[6:0], 1'b0};
							bitcnt  <= bitcnt + 3'h1;
							if (bitcnt == 3'h7)
								state <= S_TXACK;
						end
					endcase
				end
				S_TXACK: if (adv) begin
					q <= q + 2'h1;
					case (q)
						2'h0: sda_low <= 1'b0;
						2'h1: scl_low <= 1'b0;
						2'h2: o_nack_seen <= o_nack_seen | sda_s;
						default: begin
							scl_low <= 1'b1;
							// a refused byte ends with a stop
							if (o_nack_seen)
								state <= S_STOP;
							else if (stage == ST_AW) begin
								stage <= ST_PTR;
								shreg <= ptr;
								state <= S_TX;
							end else if (stage == ST_PTR && is_read) begin
								stage <= ST_AR; // [RL22]
								state <= S_START;
							end else if (stage == ST_PTR) begin
								stage <= ST_WD;
								shreg <= wbyte; // [RL4]
								state <= S_TX;
							end else if (stage == ST_WD)
								state <= S_STOP;
							else begin
								rx_idx <= 3'h0;
								bitcnt <= 3'h0;
								state  <= S_RX;
							end
						end
					endcase
				end
				S_RX: if (adv) begin
					q <= q + 2'h1;
					case (q)
						2'h0: sda_low <= 1'b0;
						2'h1: scl_low <= 1'b0;
						2'h2: shreg <= {shreg[6:0], sda_s};
						default: begin
							scl_low <= 1'b1;
							bitcnt  <= bitcnt + 3'h1;
							if (bitcnt == 3'h7) begin
								o_data_bytes[{rx_idx, 3'h0} +: 8] <= shreg; // [RL3] [RL17]
								state <= S_RXACK;
							end
						end
					endcase
				end
				S_RXACK: if (adv) begin
					q <= q + 2'h1;
					case (q)
						2'h0: sda_low <= ~last_rx; // [RL22]
						2'h1: scl_low <= 1'b0;
						2'h2: scl_low <= 1'b0;
						default: begin
							scl_low <= 1'b1;
							if (last_rx)
								state <= S_STOP;
							else begin
								rx_idx <= rx_idx + 3'h1;
								state  <= S_RX;
							end
						end
					endcase
				end
				S_STOP: if (adv) begin
					q <= q + 2'h1;
					case (q)
						2'h0: sda_low <= 1'b1;
						2'h1: scl_low <= 1'b0;
						2'h2: sda_low <= 1'b0;
						default: begin
							state       <= S_IDLE;
							o_link_busy <= 1'b0; // [RL6]
							done_loop   <= is_read & loop_xfer;
						end
					endcase
				end
				default: state <= S_IDLE;
			endcase
			// loop triggers queue; set placed last wins over the take
			if (data_mode && per_cnt == trig_point)
				pend_wr <= 1'b1; // [RL10] [RL12]
			if (data_mode && per_cnt == 32'h0)
				pend_rd <= 1'b1; // [RL7]
			if (!data_mode) begin
				pend_wr <= 1'b0; // [RL13]
				pend_rd <= 1'b0;
			end
		end
	end

	assign o_scl    = 1'b0;
	assign o_scl_oe = scl_low;
	assign o_sda    = 1'b0;
	assign o_sda_oe = sda_low;

	// only full bursts reach the ready bit in byte six
	assign new_sample = done_loop & ((rd_len != 4'h8)
	                    | o_data_bytes[`SAMPLE_RDY_BIT]); // [RL7] [RL11]

	// sticky flags; set wins over clear
	always @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_drdy_aux     <= 1'b0;
			o_int_aux_drdy <= 1'b0;
			pulse_cnt      <= 32'h0;
		end else begin
			if (new_sample)
				o_drdy_aux <= 1'b1; // [RL8]
			else if (i_data_read)
				o_drdy_aux <= 1'b0; // [RL9]
			if (new_sample)
				o_int_aux_drdy <= 1'b1; // [RL8] [RL18]
			else if (i_status1_read)
				o_int_aux_drdy <= 1'b0; // [RL9] [RL18] [RL19]
			if (new_sample)
				pulse_cnt <= NL_PULSE_CYC; // [RL8]
			else if (pulse_cnt != 32'h0)
				pulse_cnt <= pulse_cnt - 32'h1;
		end
	end

	// latched pins follow the flag, non-latched the pulse
	assign irq_level = i_latch_mode ? o_int_aux_drdy
	                   : (pulse_cnt != 32'h0); // [RL18] [RL19]
	assign drv1 = pin_drive(irq_level & i_map_pin_one, i_pin_one_out_en,
	                        i_pin_one_drain_style_select, i_pin_one_active_high); // [RL20] [RL21]
	assign drv2 = pin_drive(irq_level & i_map_pin_two, i_pin_two_out_en,
	                        i_pin_two_drain_style_select, i_pin_two_active_high); // [RL20] [RL21]
	assign o_irq_pin_one    = drv1[0];
	assign o_irq_pin_one_oe = drv1[1];
	assign o_irq_pin_two    = drv2[0];
	assign o_irq_pin_two_oe = drv2[1];

	// with both enables the input sees the own output
	assign o_queue_mark_pin_one = i_pin_one_input_en & (i_pin_one_out_en
	                              ? (drv1[1] ? drv1[0] : 1'b1) : pin1_sync[1]); // [RL21]
	assign o_queue_mark_pin_two = i_pin_two_input_en & (i_pin_two_out_en
	                              ? (drv2[1] ? drv2[0] : 1'b1) : pin2_sync[1]); // [RL21]

	// sample queue
	aux_byte_fifo #(
		.WIDTH (`FIFO_WIDTH),
		.DEPTH (`FIFO_DEPTH),
		.AW    (5)
	) u_fifo (
		.i_clk_sys   (i_clk_sys),
		.i_resetn    (i_resetn),
		.i_in_valid  (fifo_push),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (shreg),
		.o_out_valid (o_fifo_valid),
		.i_out_ready (i_fifo_ready),
		.o_out_data  (o_fifo_data)
	);
endmodule // aux_sensor_i2c_hub
